/* rtl/anp_next_page_tx.sv */
// Next-page transmit register behind an AXI4-Lite slave port.
// Assumes the arbitration logic runs on clk_sys and pulses word_sent per exchange.
`timescale 1ns/1ps
module anp_next_page_tx (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic                       clk_en,
  input  wire logic [anp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [anp_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       word_sent,
  input  wire logic                       word_sent_toggle,
  output anp_pkg::anp_word_type           np_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic                       more_ff;
  logic                       type_ff;
  logic                       ack_ff;
  logic                       tog_ff;
  logic [anp_pkg::CODE_W-1:0] code_ff;

  logic                       aw_held_ff;
  logic [anp_pkg::ADDR_W-1:0] awaddr_ff;
  logic                       w_held_ff;
  logic [31:0]                wdata_ff;
  logic [3:0]                 wstrb_ff;
  logic                       bvalid_ff;
  logic [1:0]                 bresp_ff;
  logic                       rvalid_ff;
  logic [31:0]                rdata_ff;
  logic [1:0]                 rresp_ff;

  anp_pkg::anp_word_type cur_word;
  anp_pkg::anp_word_type nxt_word;
  logic [15:0]           lane_mask;
  logic                  do_write;
  logic                  aw_take;
  logic                  w_take;
  logic                  ar_take;
  logic                  hit_wr;
  logic                  rd_hit;
  logic                  wr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Assembled word
  always_comb begin
    cur_word.more_pages_request = more_ff;
    cur_word.reserved           = 1'h0;
    cur_word.page_type_select   = type_ff;
    cur_word.comply_acknowledge = ack_ff;
    cur_word.sent_word_toggle   = tog_ff;
    cur_word.code               = code_ff;
  end

  assign np_word = cur_word;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes; gated by clk_en so no beat is taken while frozen
  assign s_axi_awready = clk_en & ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = clk_en & ~w_held_ff & ~bvalid_ff;
  assign s_axi_arready = clk_en & ~rvalid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Answers; the valids also drop while frozen
  assign s_axi_bvalid  = clk_en & bvalid_ff;
  assign s_axi_rvalid  = clk_en & rvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Beats taken and address decode
  assign aw_take  = s_axi_awvalid & s_axi_awready;
  assign w_take   = s_axi_wvalid & s_axi_wready;
  assign ar_take  = s_axi_arvalid & s_axi_arready;
  assign do_write = clk_en & aw_held_ff & w_held_ff & ~bvalid_ff;
  assign hit_wr   = (awaddr_ff == anp_pkg::NPT_ADDR);
  assign rd_hit   = (s_axi_araddr == anp_pkg::NPT_ADDR);
  assign wr_hit   = do_write & hit_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Only the two low byte lanes map onto the 16-bit word
  assign lane_mask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign nxt_word  = anp_pkg::anp_word_type'((16'(cur_word) & ~lane_mask)
                                             | (wdata_ff[15:0] & lane_mask));

  ////////////////////////////////////////////////////////////////////////////
  // Write address holding flag, dropped when the pair is consumed
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_held_ff <= 1'h0;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_held_ff <= 1'h1;
      end else if (do_write) begin
        aw_held_ff <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write address, taken in either order with the data
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      awaddr_ff <= '0;
    end else if (clk_en) begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data holding flag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      w_held_ff <= 1'h0;
    end else if (clk_en) begin
      if (w_take) begin
        w_held_ff <= 1'h1;
      end else if (do_write) begin
        w_held_ff <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wdata_ff <= '0;
    end else if (clk_en) begin
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte strobes; only the two low lanes are ever used
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wstrb_ff <= '0;
    end else if (clk_en) begin
      if (w_take) begin
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write answer; new beats wait until it is accepted
  // Holding both channels keeps one write in flight at most
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bvalid_ff <= 1'h0;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid_ff <= 1'h1;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write answer code; decode error for any other address
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bresp_ff <= anp_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        bresp_ff <= hit_wr ? anp_pkg::RESP_OKAY : anp_pkg::RESP_DECERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // More-pages request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      more_ff <= anp_pkg::MORE_RST;
    end else if (clk_en) begin
      if (wr_hit) begin
        more_ff <= nxt_word.more_pages_request;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page type select
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      type_ff <= anp_pkg::TYPE_RST;
    end else if (clk_en) begin
      if (wr_hit) begin
        type_ff <= nxt_word.page_type_select;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comply acknowledge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= anp_pkg::ACK_RST;
    end else if (clk_en) begin
      if (wr_hit) begin
        ack_ff <= nxt_word.comply_acknowledge;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code field, null page after reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      code_ff <= anp_pkg::CODE_RST;
    end else if (clk_en) begin
      if (wr_hit) begin
        code_ff <= nxt_word.code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Toggle follows the arbitration, never software
  // Stored inverted so the next word always alternates
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tog_ff <= anp_pkg::TOG_RST;
    end else if (clk_en) begin
      if (word_sent) begin
        tog_ff <= ~word_sent_toggle;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer valid, independent of the write side
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rvalid_ff <= 1'h0;
    end else if (clk_en) begin
      if (ar_take) begin
        rvalid_ff <= 1'h1;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, sampled at the address handshake
  // A write landing in that cycle shows on the next read
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else if (clk_en) begin
      if (ar_take) begin
        if (rd_hit) begin
          rdata_ff <= {16'h0000, 16'(cur_word)};
        end else begin
          rdata_ff <= 32'h00000000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer code; misses answer zero with a decode error
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rresp_ff <= anp_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        if (rd_hit) begin
          rresp_ff <= anp_pkg::RESP_OKAY;
        end else begin
          rresp_ff <= anp_pkg::RESP_DECERR;
        end
      end
    end
  end

endmodule : anp_next_page_tx

/* rtl/anp_pkg.sv */
// Constants and carrier types of the next-page transmit register bank.
// Assumes an AXI4-Lite master with 32-bit data on the same clock.
package anp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address map
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned NPT_INDEX = 7;
  localparam logic [ADDR_W-1:0] NPT_ADDR = ADDR_W'(NPT_INDEX * 4);

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the 16-bit word
  localparam int unsigned MORE_BIT = 15;
  localparam int unsigned RSVD_BIT = 14;
  localparam int unsigned TYPE_BIT = 13;
  localparam int unsigned ACK_BIT  = 12;
  localparam int unsigned TOG_BIT  = 11;
  localparam int unsigned CODE_MSB = 10;
  localparam int unsigned CODE_W   = CODE_MSB + 1;
  localparam int unsigned WORD_W   = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic              MORE_RST = 1'h0;
  localparam logic              TYPE_RST = 1'h1;
  localparam logic              ACK_RST  = 1'h0;
  localparam logic              TOG_RST  = 1'h0;
  localparam logic [CODE_W-1:0] CODE_RST = 11'h001;

  ////////////////////////////////////////////////////////////////////////////
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Field order matches the bit positions above
  typedef struct packed {
    logic              more_pages_request;
    logic              reserved;
    logic              page_type_select;
    logic              comply_acknowledge;
    logic              sent_word_toggle;
    logic [CODE_W-1:0] code;
  } anp_word_type;

endpackage : anp_pkg

/* verification/anp_next_page_tx_chk.sv */
// Checker of the next-page transmit register, on top-level ports only.
// Assumes one clock domain and binding to anp_next_page_tx.
`timescale 1ns/1ps
module anp_next_page_tx_chk (
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  input wire logic                  clk_en,
  input wire logic                  s_axi_bvalid,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  word_sent,
  input wire logic                  word_sent_toggle,
  input wire anp_pkg::anp_word_type np_word
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  property p_rst_value;
    disable iff (1'b0) !rstn |-> np_word == 16'h2001;
  endproperty
  a_rst_value: assert property (p_rst_value) else $error("reset word wrong");
  property p_rsvd_word;
    np_word.reserved == 1'b0;
  endproperty
  a_rsvd_word: assert property (p_rsvd_word) else $error("reserved bit set");
  property p_rsvd_read;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[14] == 1'b0;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("read zero bits set");
  property p_tog_capture;
    word_sent && clk_en |=> np_word.sent_word_toggle == !$past(word_sent_toggle);
  endproperty
  a_tog_capture: assert property (p_tog_capture) else $error("toggle not inverse");
  property p_tog_hold;
    !(word_sent && clk_en) |=> $stable(np_word.sent_word_toggle);
  endproperty
  a_tog_hold: assert property (p_tog_hold) else $error("toggle moved alone");
  // Fields may only move at the edge that raises the write answer
  property p_fields_hold;
    clk_en && !$rose(s_axi_bvalid) |-> $stable({np_word.more_pages_request,
      np_word.page_type_select, np_word.comply_acknowledge, np_word.code});
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("field moved alone");
endmodule : anp_next_page_tx_chk

bind anp_next_page_tx anp_next_page_tx_chk anp_next_page_tx_chk_inst (
  .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .word_sent(word_sent),
  .word_sent_toggle(word_sent_toggle), .np_word(np_word));

/* verification/tb_top.sv */
// Self-checking bench of the next-page transmit register over AXI4-Lite.
// Assumes the checker binds itself; the bench drives every port directly.
`timescale 1ns/1ps
module tb_top;
  logic                  clk_sys = 1'b0, rstn = 1'b1, clk_en = 1'b1;
  logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]           wdata = 32'h0, rdata;
  logic [3:0]            wstrb = 4'h0;
  logic [1:0]            bresp, rresp;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                  arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic                  word_sent = 1'b0, word_sent_toggle = 1'b0;
  anp_pkg::anp_word_type np_word;
  logic [15:0]           model = 16'h2001;
  int                    mismatches = 0, total_checks = 0;
  always #4 clk_sys = ~clk_sys;
  anp_next_page_tx anp_next_page_tx_inst (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .word_sent(word_sent),
    .word_sent_toggle(word_sent_toggle), .np_word(np_word));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic guard(input int n);
    if (n > 50) begin
      mismatches++;
      report_and_stop();
    end
  endtask : guard
  // Bits 14 and 11 never take bus data
  function automatic logic [15:0] apply_wr(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & 16'hB7FF;
    return (old & ~m) | (d[15:0] & m);
  endfunction : apply_wr
  // Write, then read the same place back and compare both answers
  task automatic access(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int         n;
    logic       hit;
    logic [1:0] exp_resp;
    hit = (a == anp_pkg::NPT_ADDR);
    exp_resp = hit ? anp_pkg::RESP_OKAY : anp_pkg::RESP_DECERR;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      guard(n++);
    end while (!bvalid);
    chk("bresp", 32'(exp_resp), 32'(bresp));
    bready  <= 1'b0;
    if (hit) model = apply_wr(model, d, s);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      guard(n++);
    end while (!rvalid);
    chk("rresp", 32'(exp_resp), 32'(rresp));
    chk("rdata", hit ? {16'h0, model} : 32'h0, rdata);
    chk("np_word", {16'h0, model}, {16'h0, np_word});
    rready  <= 1'b0;
    @(posedge clk_sys);
  endtask : access
  task automatic pulse(input logic t);
    word_sent        <= 1'b1;
    word_sent_toggle <= t;
    @(posedge clk_sys);
    word_sent <= 1'b0;
    if (clk_en) model[11] = ~t;
    @(posedge clk_sys);
    chk("np_word", {16'h0, model}, {16'h0, np_word});
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn <= 1'b0;
    void'($urandom(32'h2319));
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    chk("reset word", 32'h2001, {16'h0, np_word});
    access(anp_pkg::NPT_ADDR, 32'hFFFF_FFFF, 4'h0);
    access(anp_pkg::NPT_ADDR, 32'hFFFF_FFFF, 4'hF);
    access(anp_pkg::NPT_ADDR, 32'h0000_0000, 4'h3);
    pulse(1'b1);
    pulse(1'b0);
    // Frozen clock enable must ignore the exchange pulse
    clk_en <= 1'b0;
    pulse(model[11]);
    clk_en <= 1'b1;
    access(8'h18, 32'h0000_FFFF, 4'hF);
    for (int i = 0; i < 40; i++) begin
      if ($urandom() % 2 == 0) pulse(1'($urandom()));
      access($urandom() % 4 == 0 ? 8'($urandom()) : anp_pkg::NPT_ADDR,
             $urandom(), 4'($urandom()));
    end
    // Reset in mid-run must bring back every default
    pulse(1'b0);
    access(anp_pkg::NPT_ADDR, 32'h0000_D5AA, 4'h3);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("reset word", 32'h2001, {16'h0, np_word});
    rstn  <= 1'b1;
    model = 16'h2001;
    access(anp_pkg::NPT_ADDR, 32'h0000_0000, 4'h0);
    report_and_stop();
  end
endmodule : tb_top
